// file: include/dsr_pkg.sv
/*
 * Shared constants, carrier types and decode helpers for the dual-core
 * shared-resource fabric: handshake channels, message RAMs, shared RAM
 * blocks and the analog common bus front end.
 * Assumes one APB clock and reset for every requester port.
 */
`default_nettype none

package dsr_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NPORT = 3;
	localparam int HS_CH = 32;
	localparam int HS_IRQ = 4;
	localparam int EOC_N = 8;
	localparam int SH_BLOCKS = 8;
	localparam int NRAM = SH_BLOCKS + 2;
	localparam int AN_N = 8;
	localparam int AN_IDX_W = 3;
	localparam int ADC_W = 12;
	localparam int STS_W = 10;
	localparam int STS_PERR = 8;
	localparam int STS_DENY = 9;
	localparam int PAR_BIT = 32;
	localparam int WORD_LSB = 2;
	localparam int SPAN_IDX_W = 4;
	localparam int SH_BLK_LSB = 6;
	localparam int MAX_RAM_WORDS = 16;

	localparam logic [ADDR_W-1:0] OFS_M2C_SET = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_M2C_FLG = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_M2C_ACK = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_C2M_SET = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_C2M_FLG = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_C2M_ACK = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 12'h018;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 12'h01C;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_SH_DIR = 12'h024;
	localparam logic [ADDR_W-1:0] M2C_BASE = 12'h100;
	localparam logic [ADDR_W-1:0] C2M_BASE = 12'h200;
	localparam logic [ADDR_W-1:0] SH_BASE = 12'h400;
	localparam logic [ADDR_W-1:0] ARES_BASE = 12'h800;
	localparam logic [ADDR_W-1:0] ACTL_BASE = 12'h840;
	localparam logic [ADDR_W-1:0] RAM_SPAN = 12'h040;
	localparam logic [ADDR_W-1:0] AN_SPAN = 12'h020;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic dma;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} dsr_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [DATA_W-1:0] prdata;
	} dsr_apb_rsp_t;

	typedef logic [AN_N-1:0][ADC_W-1:0] dsr_results_t;
	typedef logic [AN_N-1:0][DATA_W-1:0] dsr_actrl_t;

	typedef enum logic [2:0] {
		RG_NONE = 3'b000,
		RG_CFG = 3'b001,
		RG_M2C = 3'b010,
		RG_C2M = 3'b011,
		RG_SH = 3'b100,
		RG_ARES = 3'b101,
		RG_ACTL = 3'b110
	} dsr_region_t;

	// bit 1 set means control side
	typedef enum logic [1:0] {
		CL_MCPU = 2'b00,
		CL_MDMA = 2'b01,
		CL_CCPU = 2'b10,
		CL_CDMA = 2'b11
	} dsr_cls_t;

	typedef struct packed {
		logic [NPORT-1:0] rdy;
		logic [NPORT-1:0] err;
		logic [NPORT-1:0][DATA_W-1:0] rdata;
		logic [1:0] last;
		logic [HS_CH-1:0] m2c_flag;
		logic [HS_CH-1:0] c2m_flag;
		logic [HS_IRQ-1:0] c_hs_irq;
		logic [HS_IRQ-1:0] m_hs_irq;
		logic [SH_BLOCKS-1:0] dir;
		logic [STS_W-1:0] sts;
		logic [STS_W-1:0] en;
		logic irq;
		logic [EOC_N-1:0] eoc;
		dsr_actrl_t actrl;
	} dsr_state_t;

	function automatic dsr_region_t region_of(input logic [ADDR_W-1:0] a);
		region_of = RG_NONE;
		if (a <= OFS_SH_DIR)
			region_of = RG_CFG;
		else if (a >= M2C_BASE && a < M2C_BASE + RAM_SPAN)
			region_of = RG_M2C;
		else if (a >= C2M_BASE && a < C2M_BASE + RAM_SPAN)
			region_of = RG_C2M;
		else if (a >= SH_BASE && a < SH_BASE + ADDR_W'(SH_BLOCKS) * RAM_SPAN)
			region_of = RG_SH;
		else if (a >= ARES_BASE && a < ARES_BASE + AN_SPAN)
			region_of = RG_ARES;
		else if (a >= ACTL_BASE && a < ACTL_BASE + AN_SPAN)
			region_of = RG_ACTL;
	endfunction : region_of

	function automatic logic rights_ok(input dsr_region_t rg, input dsr_cls_t cls,
		input logic wr, input logic [ADDR_W-1:0] a, input logic dir_bit);
		rights_ok = 1'b0;
		case (rg)
			RG_CFG:
			begin
				if (cls == CL_CDMA)
					rights_ok = 1'b0;
				else if (!wr)
					rights_ok = 1'b1;
				else if (a == OFS_M2C_SET || a == OFS_C2M_ACK || a == OFS_SH_DIR)
					rights_ok = !cls[1];
				else if (a == OFS_M2C_ACK || a == OFS_C2M_SET)
					rights_ok = cls[1];
				else
					rights_ok = (a == OFS_IRQ_CLR || a == OFS_IRQ_EN);
			end
			RG_M2C: rights_ok = !wr || !cls[1];
			RG_C2M: rights_ok = !wr || cls[1];
			RG_SH: rights_ok = !wr || (cls[1] == dir_bit);
			RG_ARES: rights_ok = !wr;
			RG_ACTL: rights_ok = (cls == CL_CCPU);
			default: rights_ok = 1'b0;
		endcase
	endfunction : rights_ok

	// nearest pending port after the last one served wins
	function automatic logic [1:0] rr_pick(input logic [NPORT-1:0] pend, input logic [1:0] last);
		int t;
		rr_pick = last;
		for (int k = NPORT; k >= 1; k--)
		begin
			t = int'(last) + k;
			if (t >= NPORT)
				t = t - NPORT;
			if (pend[t])
				rr_pick = 2'(t);
		end
	endfunction : rr_pick

endpackage : dsr_pkg

`default_nettype wire

// file: verilog/dsr_par_ram.sv
/*
 * Flip-flop word store with one even-parity bit per word.
 * Assumes a single writer per cycle and a registered read path in the parent.
 */
`default_nettype none

module dsr_par_ram #(
	parameter int WORDS = 16,
	localparam int IW = $clog2(WORDS)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic we,
	input wire logic [IW-1:0] idx,
	input wire logic [dsr_pkg::DATA_W-1:0] wdata,
	output logic [dsr_pkg::DATA_W-1:0] rdata,
	output logic perr
);
	import dsr_pkg::*;

	typedef struct packed {
		logic [WORDS-1:0][PAR_BIT:0] mem;
	} dsr_ram_state_t;

	dsr_ram_state_t q;
	dsr_ram_state_t d;

	generate
		if (WORDS < 2)
		begin : g_bad
			$error("dsr_par_ram needs at least two words");
		end
	endgenerate

	always_comb
	begin
		d = q;
		if (we)
			d.mem[idx] = {^wdata, wdata};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign rdata = q.mem[idx][DATA_W-1:0];
	// an odd count of ones over data and parity marks a corrupt word
	assign perr = ^q.mem[idx];

	// a word read back right after its write must carry good parity
	chk_ram_parity_gen: assert property (
		@(posedge pclk) disable iff (!presetn) we |=> !perr || $changed(idx))
		else $error("freshly written word reads back with a parity fault");

endmodule : dsr_par_ram

`default_nettype wire

// file: verilog/dsr_shared_fabric.sv
/*
 * Shared-resource fabric: three APB slave ports (master system bus, master
 * DMA bus, control bus with a DMA marker), handshake flags, parity RAMs,
 * analog register front end, end-of-conversion merge and one interrupt line.
 * Assumes all requesters share pclk and presetn.
 */
`default_nettype none

module dsr_shared_fabric #(
	parameter int RAM_WORDS = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire dsr_pkg::dsr_apb_req_t m_sys_req,
	output var dsr_pkg::dsr_apb_rsp_t m_sys_rsp,
	input wire dsr_pkg::dsr_apb_req_t m_dma_req,
	output var dsr_pkg::dsr_apb_rsp_t m_dma_rsp,
	input wire dsr_pkg::dsr_apb_req_t c_req,
	output var dsr_pkg::dsr_apb_rsp_t c_rsp,
	input wire logic [dsr_pkg::EOC_N-1:0] adc1_eoc,
	input wire logic [dsr_pkg::EOC_N-1:0] adc2_eoc,
	input wire dsr_pkg::dsr_results_t adc_result,
	output var dsr_pkg::dsr_actrl_t analog_ctrl,
	output var logic [dsr_pkg::HS_IRQ-1:0] control_interrupt_expander_hs,
	output var logic [dsr_pkg::HS_IRQ-1:0] master_vectored_int_ctrl_hs,
	output var logic [dsr_pkg::EOC_N-1:0] eoc_irq_ctl,
	output var logic [dsr_pkg::EOC_N-1:0] eoc_irq_mst,
	output var logic irq
);
	import dsr_pkg::*;

	localparam int IW = $clog2(RAM_WORDS);

	generate
		if (RAM_WORDS < 2 || RAM_WORDS > MAX_RAM_WORDS || (RAM_WORDS & (RAM_WORDS - 1)) != 0)
		begin : g_bad
			$error("RAM_WORDS must be a power of two from 2 to 16");
		end
	endgenerate

	dsr_state_t q;
	dsr_state_t d;

	dsr_apb_req_t [NPORT-1:0] req_a;
	logic [NPORT-1:0] pend;
	logic srv;
	logic [1:0] gnt;
	dsr_apb_req_t cur;
	dsr_cls_t cls;
	dsr_region_t rg;
	logic [ADDR_W-1:0] sh_off;
	logic [2:0] blk;
	logic [3:0] ram_sel;
	logic is_ram;
	logic idx_ok;
	logic ok;
	logic acc_perr;
	logic [IW-1:0] ridx;
	logic [AN_IDX_W-1:0] aidx;
	logic [NRAM-1:0][DATA_W-1:0] ram_rd;
	logic [NRAM-1:0] ram_pe;
	logic [NRAM-1:0] ram_we;

	// master CPU and DMA come in on their own ports
	assign req_a = {c_req, m_dma_req, m_sys_req};

	always_comb
	begin
		for (int i = 0; i < NPORT; i++)
			pend[i] = req_a[i].psel & req_a[i].penable & ~q.rdy[i];
	end

	// one access per cycle across all ports keeps the analog bus single-owner
	assign srv = |pend;
	assign gnt = rr_pick(pend, q.last);
	assign cur = req_a[gnt];
	assign cls = (gnt == 2'd0) ? CL_MCPU
		: (gnt == 2'd1) ? CL_MDMA
		: (cur.dma ? CL_CDMA : CL_CCPU);
	assign rg = region_of(cur.paddr);
	assign sh_off = cur.paddr - SH_BASE;
	assign blk = sh_off[SH_BLK_LSB +: 3];
	assign is_ram = (rg == RG_M2C) || (rg == RG_C2M) || (rg == RG_SH);
	assign ram_sel = (rg == RG_M2C) ? 4'h0 : (rg == RG_C2M) ? 4'h1 : 4'({1'b0, blk}) + 4'h2;
	assign ridx = cur.paddr[WORD_LSB +: IW];
	assign aidx = cur.paddr[WORD_LSB +: AN_IDX_W];
	assign idx_ok = 32'(cur.paddr[WORD_LSB +: SPAN_IDX_W]) < RAM_WORDS;
	assign ok = rights_ok(rg, cls, cur.pwrite, cur.paddr, q.dir[blk]) && (!is_ram || idx_ok);
	assign acc_perr = srv && ok && is_ram && !cur.pwrite && ram_pe[ram_sel];

	generate
		for (genvar g = 0; g < NRAM; g++)
		begin : g_ram
			// no write strobe reaches a RAM unless the rights check passed
			assign ram_we[g] = srv && ok && is_ram && cur.pwrite && (ram_sel == 4'(g));

			dsr_par_ram #(
				.WORDS(RAM_WORDS)
			) u_ram (
				.pclk(pclk),
				.presetn(presetn),
				.we(ram_we[g]),
				.idx(ridx),
				.wdata(cur.pwdata),
				.rdata(ram_rd[g]),
				.perr(ram_pe[g])
			);
		end
	endgenerate

	always_comb
	begin
		logic [HS_CH-1:0] m2c_set;
		logic [HS_CH-1:0] m2c_ack;
		logic [HS_CH-1:0] c2m_set;
		logic [HS_CH-1:0] c2m_ack;
		logic [STS_W-1:0] sts_clr;
		logic [STS_W-1:0] ev;
		logic [DATA_W-1:0] rv;
		m2c_set = '0;
		m2c_ack = '0;
		c2m_set = '0;
		c2m_ack = '0;
		sts_clr = '0;
		ev = '0;
		rv = '0;
		d = q;
		d.rdy = '0;
		d.err = '0;
		d.eoc = adc1_eoc & adc2_eoc;
		ev[EOC_N-1:0] = d.eoc & ~q.eoc;
		if (srv)
		begin
			d.rdy[gnt] = 1'b1;
			d.last = gnt;
			d.err[gnt] = !ok || acc_perr;
			ev[STS_DENY] = !ok;
			ev[STS_PERR] = acc_perr;
			if (ok && cur.pwrite)
			begin
				case (rg)
					RG_CFG:
					begin
						case (cur.paddr)
							OFS_M2C_SET: m2c_set = cur.pwdata;
							OFS_M2C_ACK: m2c_ack = cur.pwdata;
							OFS_C2M_SET: c2m_set = cur.pwdata;
							OFS_C2M_ACK: c2m_ack = cur.pwdata;
							OFS_IRQ_CLR: sts_clr = cur.pwdata[STS_W-1:0];
							OFS_IRQ_EN: d.en = cur.pwdata[STS_W-1:0];
							OFS_SH_DIR: d.dir = cur.pwdata[SH_BLOCKS-1:0];
							default: sts_clr = '0;
						endcase
					end
					RG_ACTL: d.actrl[aidx] = cur.pwdata;
					default: sts_clr = '0;
				endcase
			end
			else if (ok)
			begin
				case (rg)
					RG_CFG:
					begin
						case (cur.paddr)
							OFS_M2C_FLG: rv = q.m2c_flag;
							OFS_C2M_FLG: rv = q.c2m_flag;
							OFS_IRQ_STS: rv = DATA_W'(q.sts);
							OFS_IRQ_EN: rv = DATA_W'(q.en);
							OFS_SH_DIR: rv = DATA_W'(q.dir);
							default: rv = '0;
						endcase
					end
					RG_M2C, RG_C2M, RG_SH: rv = ram_rd[ram_sel];
					RG_ARES: rv = DATA_W'(adc_result[aidx]);
					RG_ACTL: rv = q.actrl[aidx];
					default: rv = '0;
				endcase
			end
			d.rdata[gnt] = rv;
		end
		// a set arriving with an acknowledge of the same bit wins
		d.m2c_flag = (q.m2c_flag & ~m2c_ack) | m2c_set;
		d.c2m_flag = (q.c2m_flag & ~c2m_ack) | c2m_set;
		d.c_hs_irq = q.m2c_flag[HS_IRQ-1:0];
		d.m_hs_irq = q.c2m_flag[HS_IRQ-1:0];
		d.sts = (q.sts & ~sts_clr) | ev;
		d.irq = |(d.sts & d.en);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= d;
	end

	assign m_sys_rsp = '{pready: q.rdy[0], pslverr: q.err[0], prdata: q.rdata[0]};
	assign m_dma_rsp = '{pready: q.rdy[1], pslverr: q.err[1], prdata: q.rdata[1]};
	assign c_rsp = '{pready: q.rdy[2], pslverr: q.err[2], prdata: q.rdata[2]};
	assign analog_ctrl = q.actrl;
	assign control_interrupt_expander_hs = q.c_hs_irq;
	assign master_vectored_int_ctrl_hs = q.m_hs_irq;
	// both subsystems see the same merged flop, so they never disagree
	assign eoc_irq_ctl = q.eoc;
	assign eoc_irq_mst = q.eoc;
	assign irq = q.irq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_mst_set0;
		srv && gnt == 2'd0 && ok && cur.pwrite && cur.paddr == OFS_M2C_SET && cur.pwdata[0];
	endsequence

	sequence s_ctl_set1;
		srv && gnt == 2'd2 && ok && cur.pwrite && cur.paddr == OFS_C2M_SET && cur.pwdata[1];
	endsequence

	sequence s_cdma_hs;
		srv && cls == CL_CDMA && rg == RG_CFG;
	endsequence

	// flag lands one edge after the write, the interrupt line one edge later
	sequence s_m2c_flag0_seen;
		##1 q.m2c_flag[0] ##1 control_interrupt_expander_hs[0];
	endsequence

	chk_hs_irq_path: assert property (
		s_mst_set0 |-> s_m2c_flag0_seen)
		else $error("handshake interrupt did not follow a channel set");

	chk_c2m_irq_path: assert property (
		s_ctl_set1 |-> ##2 master_vectored_int_ctrl_hs[1])
		else $error("master handshake interrupt did not follow a channel set");

	chk_flag_set_wins: assert property (
		s_mst_set0 |=> q.m2c_flag[0])
		else $error("handshake flag lost its set");

	chk_cdma_hs_denied: assert property (
		s_cdma_hs |=> c_rsp.pready && c_rsp.pslverr)
		else $error("control DMA reached handshake registers");

	chk_m2c_ro_ctrl: assert property (
		srv && rg == RG_M2C && cur.pwrite && cls[1] |-> ram_we == '0 ##1 c_rsp.pslverr)
		else $error("control side wrote the master-to-control RAM");

	chk_m2c_rd_all: assert property (
		srv && rg == RG_M2C && !cur.pwrite && idx_ok && !acc_perr |=> q.err == '0)
		else $error("read of the master-to-control RAM refused");

	chk_c2m_ro_mst: assert property (
		srv && rg == RG_C2M && cur.pwrite && !cls[1] |-> ram_we == '0 ##1 q.err != '0)
		else $error("master side wrote the control-to-master RAM");

	chk_sh_dir_write: assert property (
		srv && rg == RG_SH && cur.pwrite && idx_ok && (cls[1] == q.dir[blk])
			|-> ram_we != '0 ##1 q.err == '0)
		else $error("shared block write refused in its own direction");

	chk_sh_dir_refuse: assert property (
		srv && rg == RG_SH && cur.pwrite && (cls[1] != q.dir[blk]) |-> ram_we == '0)
		else $error("shared block written against its direction");

	chk_parity_read: assert property (
		acc_perr |=> q.err != '0 && q.sts[STS_PERR])
		else $error("parity fault not reported");

	chk_one_answer: assert property (
		$onehot0({m_sys_rsp.pready, m_dma_rsp.pready, c_rsp.pready}))
		else $error("more than one port answered in a cycle");

	chk_dma_port_own: assert property (
		srv && gnt == 2'd1 |=> m_dma_rsp.pready && !m_sys_rsp.pready)
		else $error("master DMA grant answered on the wrong port");

	chk_rr_no_starve: assert property (
		pend[2] |-> ##[0:2] (srv && gnt == 2'd2))
		else $error("control port waited too long for a grant");

	chk_deny_sticky: assert property (
		srv && !ok |=> q.sts[STS_DENY] && q.err != '0)
		else $error("refused access not flagged");

	chk_analog_ctl_only: assert property (
		srv && rg == RG_ACTL && cls != CL_CCPU |=> $stable(analog_ctrl) && q.err != '0)
		else $error("analog control register reached by a non-control CPU");

	chk_eoc_and: assert property (
		adc1_eoc != adc2_eoc && (adc1_eoc & adc2_eoc) == 8'h00
			|=> eoc_irq_mst == 8'h00 && eoc_irq_ctl == 8'h00)
		else $error("end-of-conversion interrupt without both sources");

	chk_eoc_status: assert property (
		$rose(eoc_irq_mst[0]) |-> q.sts[0] && eoc_irq_ctl[0])
		else $error("end-of-conversion event missed its status bit");

	chk_ares_read: assert property (
		srv && rg == RG_ARES && !cur.pwrite
			|=> q.err == '0 && $past(adc_result[aidx]) == ADC_W'(q.rdata[$past(gnt)]))
		else $error("result register read failed");

endmodule : dsr_shared_fabric

`default_nettype wire

// file: sim/dsr_cpu_model.sv
/*
 * Behavioural model of one requester (cpu or dma engine) on a fabric port.
 * Assumes the fabric answers with a one-cycle pready; the bench bounds waits.
 */
`default_nettype none

module dsr_cpu_model (
	input wire logic pclk,
	output var dsr_pkg::dsr_apb_req_t req,
	input wire dsr_pkg::dsr_apb_rsp_t rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import dsr_pkg::*;

	initial
		req = '0;

	task automatic xfer(input logic wr, input logic dma, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic e);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, dma: dma, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1)
			@(posedge pclk);
		q = rsp.prdata;
		e = rsp.pslverr;
		// idle bus shows inverted leftovers so a stale value never looks valid
		req <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, dma: ~dma, paddr: ~a, pwdata: ~d};
	endtask : xfer

endmodule : dsr_cpu_model

`default_nettype wire

// file: sim/dsr_shared_fabric_tb.sv
/*
 * Self-checking bench: three requester models drive the fabric's ports.
 * Assumes the package and the cpu model are compiled first.
 */
`default_nettype none

module dsr_shared_fabric_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dsr_pkg::*;

	localparam int MCPU = 0;
	localparam int MDMA = 1;
	localparam int CCPU = 2;
	localparam int CDMA = 3;
	localparam logic W = 1'b1;
	localparam logic R = 1'b0;
	localparam logic OK = 1'b0;
	localparam logic ERR = 1'b1;

	logic pclk;
	logic presetn;
	dsr_apb_req_t m_sys_req;
	dsr_apb_rsp_t m_sys_rsp;
	dsr_apb_req_t m_dma_req;
	dsr_apb_rsp_t m_dma_rsp;
	dsr_apb_req_t c_req;
	dsr_apb_rsp_t c_rsp;
	logic [EOC_N-1:0] adc1_eoc;
	logic [EOC_N-1:0] adc2_eoc;
	dsr_results_t adc_result;
	dsr_actrl_t analog_ctrl;
	logic [HS_IRQ-1:0] c_hs;
	logic [HS_IRQ-1:0] m_hs;
	logic [EOC_N-1:0] eoc_ctl;
	logic [EOC_N-1:0] eoc_mst;
	logic irq;
	logic [ADDR_W-1:0] sh;
	logic [SH_BLOCKS-1:0] dir;
	int error_cnt;
	int checked;

	dsr_shared_fabric #(.RAM_WORDS(16)) u_dsr_shared_fabric (
		.pclk(pclk), .presetn(presetn),
		.m_sys_req(m_sys_req), .m_sys_rsp(m_sys_rsp),
		.m_dma_req(m_dma_req), .m_dma_rsp(m_dma_rsp),
		.c_req(c_req), .c_rsp(c_rsp),
		.adc1_eoc(adc1_eoc), .adc2_eoc(adc2_eoc), .adc_result(adc_result),
		.analog_ctrl(analog_ctrl),
		.control_interrupt_expander_hs(c_hs), .master_vectored_int_ctrl_hs(m_hs),
		.eoc_irq_ctl(eoc_ctl), .eoc_irq_mst(eoc_mst), .irq(irq)
	);
	dsr_cpu_model u_msys (.pclk(pclk), .req(m_sys_req), .rsp(m_sys_rsp));
	dsr_cpu_model u_mdma (.pclk(pclk), .req(m_dma_req), .rsp(m_dma_rsp));
	dsr_cpu_model u_ctl (.pclk(pclk), .req(c_req), .rsp(c_rsp));

	initial
	begin
		pclk = 1'b0;
		forever
			#20 pclk = ~pclk;
	end

	task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk_data

	task automatic chk_bit(input string n, input logic e, input logic g);
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	// d is write data, or the expected word for a read
	task automatic acc(input int p, input logic wr, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic ee);
		logic [DATA_W-1:0] q;
		logic e;
		case (p)
			MCPU: u_msys.xfer(wr, 1'b0, a, d, q, e);
			MDMA: u_mdma.xfer(wr, 1'b1, a, d, q, e);
			default: u_ctl.xfer(wr, p == CDMA, a, d, q, e);
		endcase
		chk_bit("pslverr", ee, e);
		if (!wr && !ee)
			chk_data("prdata", d, q);
	endtask : acc

	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask : settle

	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		presetn = 1'b0;
		adc1_eoc = '0;
		adc2_eoc = '0;
		adc_result = '0;
		error_cnt = 0;
		checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk_bit("irq", 1'b0, irq);
		chk_data("analog_ctrl", 32'h0000_0000, analog_ctrl[0]);
		acc(CCPU, R, OFS_SH_DIR, 32'h0000_0000, OK);
		acc(MCPU, W, M2C_BASE, 32'hCAFE_0001, OK);
		acc(CCPU, R, M2C_BASE, 32'hCAFE_0001, OK);
		acc(CDMA, W, M2C_BASE, 32'h0BAD_0BAD, ERR);
		acc(CDMA, R, M2C_BASE, 32'hCAFE_0001, OK);
		acc(MDMA, W, M2C_BASE + 12'h004, 32'hCAFE_0002, OK);
		acc(MDMA, R, M2C_BASE + 12'h004, 32'hCAFE_0002, OK);
		acc(CDMA, W, C2M_BASE, 32'h5EED_0003, OK);
		acc(MCPU, W, C2M_BASE, 32'h0BAD_0BAD, ERR);
		acc(MDMA, R, C2M_BASE, 32'h5EED_0003, OK);
		dir = 8'hA5;
		acc(MCPU, W, OFS_SH_DIR, 32'(dir), OK);
		acc(CDMA, R, OFS_SH_DIR, 32'(dir), ERR);
		for (int n = 0; n < SH_BLOCKS; n++)
		begin
			sh = SH_BASE + RAM_SPAN * 12'(n);
			acc(dir[n] ? MCPU : CCPU, W, sh, 32'h0BAD_0BAD, ERR);
			acc(dir[n] ? CDMA : MDMA, W, sh, 32'h1000_0000 + 32'(n), OK);
			acc(dir[n] ? MDMA : CDMA, R, sh, 32'h1000_0000 + 32'(n), OK);
		end
		acc(MCPU, W, OFS_M2C_SET, 32'h8000_0005, OK);
		acc(CCPU, R, OFS_M2C_FLG, 32'h8000_0005, OK);
		acc(CDMA, R, OFS_M2C_FLG, 32'h0000_0000, ERR);
		settle();
		chk_data("hs_ctl", 32'h0000_0005, 32'(c_hs));
		acc(CCPU, W, OFS_M2C_ACK, 32'h0000_0001, OK);
		acc(MDMA, R, OFS_M2C_FLG, 32'h8000_0004, OK);
		acc(CCPU, W, OFS_C2M_SET, 32'h0000_000A, OK);
		acc(CDMA, W, OFS_C2M_SET, 32'h0000_0001, ERR);
		settle();
		chk_data("hs_mst", 32'h0000_000A, 32'(m_hs));
		acc(MCPU, W, OFS_C2M_ACK, 32'h0000_000A, OK);
		settle();
		chk_data("hs_mst", 32'h0000_0000, 32'(m_hs));
		@(posedge pclk);
		adc_result[3] <= 12'hABC;
		acc(MDMA, R, ARES_BASE + 12'h00C, 32'h0000_0ABC, OK);
		acc(CDMA, R, ARES_BASE + 12'h00C, 32'h0000_0ABC, OK);
		acc(MCPU, W, ARES_BASE, 32'h0000_0001, ERR);
		acc(CCPU, W, ACTL_BASE + 12'h004, 32'h1234_5678, OK);
		acc(MCPU, W, ACTL_BASE + 12'h008, 32'h0BAD_0BAD, ERR);
		acc(CDMA, W, ACTL_BASE + 12'h008, 32'h0BAD_0BAD, ERR);
		acc(MDMA, R, ACTL_BASE + 12'h004, 32'h0000_0000, ERR);
		chk_data("analog_ctrl", 32'h1234_5678, analog_ctrl[1]);
		chk_data("analog_ctrl", 32'h0000_0000, analog_ctrl[2]);
		acc(CCPU, R, 12'h300, 32'h0000_0000, ERR);
		acc(MCPU, R, OFS_IRQ_CLR, 32'h0000_0000, OK);
		acc(MCPU, W, OFS_IRQ_STS, 32'h0000_0001, ERR);
		// all three ports at once, twice, so the round-robin pointer moves
		repeat (2)
			fork
				acc(MCPU, R, ARES_BASE + 12'h00C, 32'h0000_0ABC, OK);
				acc(MDMA, R, ARES_BASE + 12'h00C, 32'h0000_0ABC, OK);
				acc(CCPU, R, ACTL_BASE + 12'h004, 32'h1234_5678, OK);
			join
		acc(MCPU, W, OFS_IRQ_EN, 32'h0000_0001, OK);
		acc(CCPU, W, OFS_IRQ_CLR, 32'h0000_03FF, OK);
		@(posedge pclk);
		adc1_eoc <= 8'h81;
		settle();
		chk_data("eoc_ctl", 32'h0000_0000, 32'(eoc_ctl));
		chk_bit("irq", 1'b0, irq);
		@(posedge pclk);
		adc2_eoc <= 8'h01;
		settle();
		chk_data("eoc_ctl", 32'h0000_0001, 32'(eoc_ctl));
		chk_data("eoc_mst", 32'h0000_0001, 32'(eoc_mst));
		chk_bit("irq", 1'b1, irq);
		acc(CCPU, R, OFS_IRQ_STS, 32'h0000_0001, OK);
		acc(MCPU, W, OFS_IRQ_EN, 32'h0000_0000, OK);
		settle();
		chk_bit("irq", 1'b0, irq);
		acc(MCPU, W, OFS_IRQ_EN, 32'h0000_0001, OK);
		settle();
		chk_bit("irq", 1'b1, irq);
		@(posedge pclk);
		adc1_eoc <= 8'h00;
		adc2_eoc <= 8'h00;
		acc(CCPU, W, OFS_IRQ_CLR, 32'h0000_0001, OK);
		settle();
		chk_bit("irq", 1'b0, irq);
		acc(CDMA, R, OFS_IRQ_STS, 32'h0000_0000, ERR);
		acc(MDMA, R, OFS_IRQ_STS, 32'h0000_0200, OK);
		end_of_test();
	end

endmodule : dsr_shared_fabric_tb

`default_nettype wire
